// ---- src/stic_pkg.sv ----
// shared constants and types for the s/t interface control register bank
package stic_pkg;

  // ***************************************************************
  // register indices (byte address is four times the index)
  // ***************************************************************
  localparam logic [7:0] IDX_TIMING_CTRL = 8'h0F; // st_activation_timing_ctrl
  localparam logic [7:0] IDX_LOOP_CTRL = 8'h10; // st_loopback_deact_ctrl
  localparam logic [7:0] IDX_STATUS = 8'h11; // activation status, read only
  localparam logic [7:0] IDX_MF_A = 8'h20; // multiframe_reg_a
  localparam logic [7:0] IDX_MF_B = 8'h21; // multiframe_reg_b
  localparam logic [7:0] IDX_NONE = 8'hFF; // marks an unmapped access
  localparam int ADDR_W = 12; // decoded address bits

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int BIT_SOFT_RESET = 0;
  localparam int BIT_ENABLE = 1;
  localparam int BIT_MF_ENABLE = 2;
  localparam int BIT_FIXED_TIMING = 3;
  localparam int BIT_FORCE_ACT = 4;
  localparam int BIT_LOCAL_ACT = 5;
  localparam int BIT_FORCED_DEACT = 1;
  localparam int BIT_LOOP_B1 = 2;
  localparam int BIT_LOOP_B2 = 3;
  localparam int BIT_LOOP_D = 4;
  localparam int BIT_STAT_LOCK = 3;

  // ***************************************************************
  // values after reset and writable masks
  // ***************************************************************
  localparam logic [7:0] TIMING_RST = 8'h02;
  localparam logic [7:0] LOOP_RST = 8'h00;
  localparam logic [7:0] MF_A_RST = 8'h0F;
  localparam logic [7:0] MF_B_RST = 8'h00;
  localparam logic [7:0] TIMING_RW_MASK = 8'h3E; // bit 0 never stores
  localparam logic [7:0] LOOP_RW_MASK = 8'h1E;
  localparam logic [3:0] MF_A_FORCED = 4'hF;
  localparam logic [3:0] MF_B_FORCED = 4'h0;

  // ***************************************************************
  // ahb-lite encodings
  // ***************************************************************
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // activation state codes reported by the activation state machine
  typedef enum logic [2:0] {
    GST_DISABLED = 3'b000,
    GST_DEACTIVATED = 3'b001,
    GST_PENDING_ACT = 3'b010,
    GST_ACTIVATED = 3'b011,
    GST_PENDING_DEACT = 3'b100,
    GST_WAIT_U_SYNC = 3'b101
  } stic_gstate_e;

  // kind of bit position in the transmit frame
  typedef enum logic [2:0] {
    SLOT_B1 = 3'b000,
    SLOT_B2 = 3'b001,
    SLOT_D = 3'b010,
    SLOT_FA = 3'b011,
    SLOT_M = 3'b100,
    SLOT_S = 3'b101,
    SLOT_OTHER = 3'b110
  } stic_slot_e;

endpackage

// ---- src/stic_rx_sampler.sv ----
// receive sampler choosing a fixed or an adaptive sample point
`timescale 1ns/10ps
`default_nettype none
module stic_rx_sampler (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // line side
  input wire logic rx_pin,
  // sample point control
  input wire logic fixed_sample_timing,
  input wire logic fixed_strobe,
  input wire logic adaptive_strobe,
  // sampled data
  output logic rx_bit,
  output logic rx_bit_valid
);

  typedef struct packed {
    logic sync1; // first stage, read only by sync2
    logic sync2;
    logic sync3;
    logic filt; // value accepted once sync2 and sync3 agree
    logic bit_q;
    logic valid;
  } stic_smp_s;

  stic_smp_s s;
  stic_smp_s next_s;

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb
  begin
    next_s = s;
    next_s.sync1 = rx_pin;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    // a pin change counts only when two late stages agree
    if (s.sync2 == s.sync3)
    begin
      next_s.filt = s.sync3;
    end
    next_s.valid = 1'b0;
    if (fixed_sample_timing ? fixed_strobe : adaptive_strobe)
    begin
      next_s.bit_q = s.filt;
      next_s.valid = 1'b1;
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rx_bit = s.bit_q;
  assign rx_bit_valid = s.valid;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  fixed_point_a: assert property (fixed_sample_timing && fixed_strobe |=> rx_bit_valid && rx_bit == $past(s.filt)) else $error("fixed sample missed");
  adapt_point_a: assert property (!fixed_sample_timing && !adaptive_strobe |=> !rx_bit_valid) else $error("sample outside adaptive point");

endmodule
`default_nettype wire

// ---- src/stic_tx_select.sv ----
// transmit bit selection: multiframe override and remote loopback
`timescale 1ns/10ps
`default_nettype none
module stic_tx_select (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // frame side
  input wire logic bit_strobe,
  input wire logic [2:0] tx_slot,
  input wire logic tx_bit_in,
  input wire logic rx_loop_bit,
  // control
  input wire logic multiframe_enable,
  input wire logic loopback_d_channel,
  input wire logic loopback_b1_channel,
  input wire logic loopback_b2_channel,
  // line bit
  output logic tx_bit
);

  typedef struct packed {
    logic bit_q;
  } stic_txs_s;

  stic_txs_s s;
  stic_txs_s next_s;

  // ***************************************************************
  // per-slot choice of the outgoing bit
  // ***************************************************************
  always_comb
  begin
    next_s = s;
    if (bit_strobe)
    begin
      next_s.bit_q = tx_bit_in;
      case (stic_pkg::stic_slot_e'(tx_slot))
        stic_pkg::SLOT_B1:
        begin
          if (loopback_b1_channel) next_s.bit_q = rx_loop_bit;
        end
        stic_pkg::SLOT_B2:
        begin
          if (loopback_b2_channel) next_s.bit_q = rx_loop_bit;
        end
        stic_pkg::SLOT_D:
        begin
          if (loopback_d_channel) next_s.bit_q = rx_loop_bit;
        end
        stic_pkg::SLOT_FA, stic_pkg::SLOT_M:
        begin
          if (!multiframe_enable) next_s.bit_q = 1'b0;
        end
        stic_pkg::SLOT_S:
        begin
          if (!multiframe_enable) next_s.bit_q = 1'b1;
        end
        default:
        begin
          next_s.bit_q = tx_bit_in;
        end
      endcase
    end
  end

  // state register; idle line bit is one
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      s <= '1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tx_bit = s.bit_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  fa_m_zero_a: assert property (bit_strobe && !multiframe_enable && (tx_slot == stic_pkg::SLOT_FA || tx_slot == stic_pkg::SLOT_M) |=> !tx_bit) else $error("fa or m bit not zero");
  s_bit_one_a: assert property (bit_strobe && !multiframe_enable && tx_slot == stic_pkg::SLOT_S |=> tx_bit) else $error("s bit not one");
  loop_b1_a: assert property (bit_strobe && loopback_b1_channel && tx_slot == stic_pkg::SLOT_B1 |=> tx_bit == $past(rx_loop_bit)) else $error("b1 not looped");

endmodule
`default_nettype wire

// ---- src/stic_regs.sv ----
// s/t interface control registers with ahb-lite slave
// Notes on behaviour
// - force bit drives straight to full activation
// - force bit ignored while interface disabled
// - u activation under force locks until cleared
// - timing bit 3 clear selects adaptive sample point
// - timing bit 3 selects fixed sample delay
// - multiframe bit enables controller and s/q access
// - no multiframing: fa/m zeros, s ones
// - no multiframing: reg a low ones, b zeros
// - enable bit 0 powers interface down
// - soft reset write reinitialises the interface
// - soft reset self clears, reads zero
// - loopback/deactivation register at 0x10 resets zero
// - local-only activation behaves as u ready
// - forced deactivation bit forces deactivation
// - loopback bits return channel data to terminal
// - state code 011 means fully activated
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module stic_regs (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // activation state machine
  input wire logic [2:0] activation_state,
  input wire logic u_activation_event,
  output logic interface_enable,
  output logic force_full_activation,
  output logic local_only_activation,
  output logic forced_deactivation,
  output logic u_activation_ignore,
  output logic full_activation,
  output logic interface_soft_reset,
  // multiframing controller
  output logic multiframe_enable,
  output logic [7:0] multiframe_reg_a,
  output logic [7:0] multiframe_reg_b,
  // receive line and sample strobes
  input wire logic rx_pin,
  input wire logic fixed_strobe,
  input wire logic adaptive_strobe,
  output logic fixed_sample_timing,
  output logic rx_bit,
  output logic rx_bit_valid,
  // transmit frame
  input wire logic bit_strobe,
  input wire logic [2:0] tx_slot,
  input wire logic tx_bit_in,
  output logic loopback_d_channel,
  output logic loopback_b1_channel,
  output logic loopback_b2_channel,
  output logic tx_bit
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [7:0] timing_ctrl; // st_activation_timing_ctrl
    logic [7:0] loop_ctrl; // st_loopback_deact_ctrl
    logic [7:0] mf_a; // multiframe_reg_a
    logic [7:0] mf_b; // multiframe_reg_b
    logic u_lock; // u activation attempts ignored
    logic soft_rst; // one-cycle interface reset
    logic wr_pend; // write data phase pending
    logic [7:0] wr_idx; // index of pending write
    logic rd_timing; // last read hit the timing register
    logic [31:0] rdata; // read data for the data phase
  } stic_regs_s;

  stic_regs_s s;
  stic_regs_s next_s;
  logic addr_phase; // a transfer is taken this cycle
  logic [7:0] acc_idx; // decoded index of that transfer
  logic iface_rst_n; // reset for the interface datapath

  // map a byte address onto a register index
  function automatic logic [7:0] decode_idx(input logic [31:0] a, input logic [2:0] sz);
    logic [7:0] idx;
    idx = a[9:2];
    if (a[31:stic_pkg::ADDR_W] != '0 || a[stic_pkg::ADDR_W-1:10] != '0)
    begin
      idx = stic_pkg::IDX_NONE;
    end
    if (a[1:0] != 2'h0 || sz != stic_pkg::HSIZE_WORD)
    begin
      idx = stic_pkg::IDX_NONE;
    end
    return idx;
  endfunction

  // address phase detection
  assign addr_phase = hsel && htrans == stic_pkg::HTRANS_NONSEQ && hready;
  assign acc_idx = decode_idx(haddr, hsize);

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb
  begin
    next_s = s;
    next_s.soft_rst = 1'b0;
    // data phase of a write lands here, masked so reserved bits stay zero
    if (s.wr_pend)
    begin
      case (s.wr_idx)
        stic_pkg::IDX_TIMING_CTRL:
        begin
          next_s.timing_ctrl = hwdata[7:0] & stic_pkg::TIMING_RW_MASK;
          next_s.soft_rst = hwdata[stic_pkg::BIT_SOFT_RESET];
        end
        stic_pkg::IDX_LOOP_CTRL:
        begin
          next_s.loop_ctrl = hwdata[7:0] & stic_pkg::LOOP_RW_MASK;
        end
        stic_pkg::IDX_MF_A:
        begin
          next_s.mf_a = hwdata[7:0];
        end
        stic_pkg::IDX_MF_B:
        begin
          next_s.mf_b = hwdata[7:0];
        end
        default:
        begin
          next_s.wr_pend = 1'b0; // unmapped write ignored
        end
      endcase
    end
    // the soft reset pulse reinitialises the loopback and multiframe registers
    if (s.soft_rst)
    begin
      next_s.loop_ctrl = stic_pkg::LOOP_RST;
      next_s.mf_a = stic_pkg::MF_A_RST;
      next_s.mf_b = stic_pkg::MF_B_RST;
    end
    // multiframe register low nibbles pinned while multiframing is off
    if (!next_s.timing_ctrl[stic_pkg::BIT_MF_ENABLE])
    begin
      next_s.mf_a[3:0] = stic_pkg::MF_A_FORCED;
      next_s.mf_b[3:0] = stic_pkg::MF_B_FORCED;
    end
    // lock clears once software drops the force bit; a new event wins
    if (!s.timing_ctrl[stic_pkg::BIT_FORCE_ACT] || s.soft_rst)
    begin
      next_s.u_lock = 1'b0;
    end
    if (u_activation_event && force_full_activation)
    begin
      next_s.u_lock = 1'b1;
    end
    // new address phase; read data built from post-write values
    next_s.wr_pend = addr_phase && hwrite;
    next_s.wr_idx = acc_idx;
    next_s.rd_timing = 1'b0;
    if (addr_phase && !hwrite)
    begin
      next_s.rd_timing = acc_idx == stic_pkg::IDX_TIMING_CTRL;
      case (acc_idx)
        stic_pkg::IDX_TIMING_CTRL:
        begin
          next_s.rdata = {24'h000000, next_s.timing_ctrl};
        end
        stic_pkg::IDX_LOOP_CTRL:
        begin
          next_s.rdata = {24'h000000, next_s.loop_ctrl};
        end
        stic_pkg::IDX_STATUS:
        begin
          next_s.rdata = {24'h000000, 4'h0, next_s.u_lock, activation_state};
        end
        stic_pkg::IDX_MF_A:
        begin
          next_s.rdata = {24'h000000, next_s.mf_a};
        end
        stic_pkg::IDX_MF_B:
        begin
          next_s.rdata = {24'h000000, next_s.mf_b};
        end
        default:
        begin
          next_s.rdata = 32'h00000000; // unmapped reads zero
        end
      endcase
    end
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      s.timing_ctrl <= stic_pkg::TIMING_RST;
      s.loop_ctrl <= stic_pkg::LOOP_RST;
      s.mf_a <= stic_pkg::MF_A_RST;
      s.mf_b <= stic_pkg::MF_B_RST;
      s.u_lock <= 1'b0;
      s.soft_rst <= 1'b0;
      s.wr_pend <= 1'b0;
      s.wr_idx <= stic_pkg::IDX_NONE;
      s.rd_timing <= 1'b0;
      s.rdata <= 32'h00000000;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = stic_pkg::HRESP_OKAY;
  assign hrdata = s.rdata;
  // enable low powers the interface down and gates both activation modes
  assign interface_enable = s.timing_ctrl[stic_pkg::BIT_ENABLE];
  assign force_full_activation = s.timing_ctrl[stic_pkg::BIT_FORCE_ACT] && interface_enable;
  assign local_only_activation = s.timing_ctrl[stic_pkg::BIT_LOCAL_ACT] && interface_enable;
  assign fixed_sample_timing = s.timing_ctrl[stic_pkg::BIT_FIXED_TIMING];
  assign multiframe_enable = s.timing_ctrl[stic_pkg::BIT_MF_ENABLE];
  assign multiframe_reg_a = s.mf_a;
  assign multiframe_reg_b = s.mf_b;
  assign forced_deactivation = s.loop_ctrl[stic_pkg::BIT_FORCED_DEACT];
  assign loopback_d_channel = s.loop_ctrl[stic_pkg::BIT_LOOP_D];
  assign loopback_b1_channel = s.loop_ctrl[stic_pkg::BIT_LOOP_B1];
  assign loopback_b2_channel = s.loop_ctrl[stic_pkg::BIT_LOOP_B2];
  assign u_activation_ignore = s.u_lock;
  assign full_activation = activation_state == stic_pkg::GST_ACTIVATED;
  assign interface_soft_reset = s.soft_rst;
  // datapath is held in reset by the pin or the soft reset pulse
  assign iface_rst_n = reset_n && !s.soft_rst;

  // ***************************************************************
  // datapath
  // ***************************************************************
  stic_rx_sampler u_sampler (
    .clock(clock),
    .reset_n(iface_rst_n),
    .rx_pin(rx_pin),
    .fixed_sample_timing(fixed_sample_timing),
    .fixed_strobe(fixed_strobe),
    .adaptive_strobe(adaptive_strobe),
    .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid)
  );

  stic_tx_select u_tx_select (
    .clock(clock),
    .reset_n(iface_rst_n),
    .bit_strobe(bit_strobe),
    .tx_slot(tx_slot),
    .tx_bit_in(tx_bit_in),
    .rx_loop_bit(rx_bit),
    .multiframe_enable(multiframe_enable),
    .loopback_d_channel(loopback_d_channel),
    .loopback_b1_channel(loopback_b1_channel),
    .loopback_b2_channel(loopback_b2_channel),
    .tx_bit(tx_bit)
  );

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  soft_pulse_a: assert property (s.wr_pend && s.wr_idx == stic_pkg::IDX_TIMING_CTRL && hwdata[0] |=> interface_soft_reset ##1 !interface_soft_reset) else $error("soft reset not one pulse");
  soft_read_zero_a: assert property (s.rd_timing |-> !hrdata[0]) else $error("soft reset bit read as one");
  force_gated_a: assert property (!interface_enable |-> !force_full_activation && !local_only_activation) else $error("activation while disabled");
  force_follow_a: assert property (interface_enable && s.timing_ctrl[4] |-> force_full_activation) else $error("force bit not applied");
  u_lock_hold_a: assert property (force_full_activation && u_activation_event |=> u_activation_ignore) else $error("u lock not set");
  u_lock_clear_a: assert property (u_activation_ignore && !s.timing_ctrl[4] && !u_activation_event |=> !u_activation_ignore) else $error("u lock not released");
  mf_pinned_a: assert property (!multiframe_enable |-> multiframe_reg_a[3:0] == 4'hF && multiframe_reg_b[3:0] == 4'h0) else $error("multiframe regs not pinned");
  loop_reset_a: assert property (interface_soft_reset |=> s.loop_ctrl == 8'h00) else $error("loop register not cleared");
  reserved_zero_a: assert property (s.loop_ctrl[7:5] == 3'h0 && !s.loop_ctrl[0] && s.timing_ctrl[7:6] == 2'h0) else $error("reserved bit set");
  // a soft reset pulse in the landing cycle overrides the write and clears the register
  deact_out_a: assert property (s.wr_pend && s.wr_idx == stic_pkg::IDX_LOOP_CTRL && hwdata[1]
    && !interface_soft_reset |=> forced_deactivation) else $error("forced deactivation not driven");

  force_cover_c: cover property (force_full_activation && u_activation_event ##1 u_activation_ignore);
  soft_cover_c: cover property (interface_soft_reset);
  loop_cover_c: cover property (loopback_b1_channel && bit_strobe);
  mf_cover_c: cover property ($rose(multiframe_enable));

endmodule
`default_nettype wire

// ---- bench/stic_te_model.sv ----
// line-side model: terminal data on the receive pin plus sample strobes
`timescale 1ns/10ps
`default_nettype none
module stic_te_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // line side toward the block
  output logic rx_pin,
  output logic fixed_strobe,
  output logic adaptive_strobe
);
  // ***************************************************************
  // bit timing
  // ***************************************************************
  logic [3:0] phase; // position within one 16-cycle bit
  // new bit at phase 0 so both sample points see a settled level
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      phase <= 4'h0;
      rx_pin <= 1'b1;
      fixed_strobe <= 1'b0;
      adaptive_strobe <= 1'b0;
    end
    else
    begin
      phase <= phase + 4'h1;
      if (phase == 4'hF)
        rx_pin <= 1'($urandom);
      // the two sample points lie 4 cycles apart, so a mixup shows
      fixed_strobe <= (phase == 4'h7);
      adaptive_strobe <= (phase == 4'hB);
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the s/t control register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ***************************************************************
  // signals
  // ***************************************************************
  localparam logic [7:0] TIM = stic_pkg::IDX_TIMING_CTRL;
  localparam logic [7:0] LOOP = stic_pkg::IDX_LOOP_CTRL;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = stic_pkg::HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic hreadyout, hresp, interface_enable, force_full_activation;
  logic [31:0] hrdata;
  logic [2:0] activation_state = 3'h0;
  logic u_activation_event = 1'b0;
  logic local_only_activation, forced_deactivation, u_activation_ignore;
  logic full_activation, interface_soft_reset, multiframe_enable;
  logic [7:0] multiframe_reg_a, multiframe_reg_b;
  logic rx_pin, fixed_strobe, adaptive_strobe, fixed_sample_timing, rx_bit, rx_bit_valid;
  logic bit_strobe = 1'b0;
  logic [2:0] tx_slot = 3'h0;
  logic tx_bit_in = 1'b0;
  logic loopback_d_channel, loopback_b1_channel, loopback_b2_channel, tx_bit;
  int bad_count = 0;
  int tests_run = 0;
  int pulses = 0; // soft reset pulses seen
  logic last_rx; // pin level at the last selected strobe
  logic [31:0] d;
  assign hready = hreadyout; // single slave drives bus ready
  stic_regs i_dut (.*);
  stic_te_model i_te (.*);
  always #5 clock = ~clock;
  // count every cycle the soft reset pulse is up
  always @(posedge clock)
    if (interface_soft_reset === 1'b1)
      pulses++;
  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic report_and_stop;
    $display("counts: tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait on bus ready; a stuck bus ends the run
  task automatic wait_rdy;
    int n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1)
    begin
      bad_count++;
      report_and_stop;
    end
  endtask
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clock);
    haddr <= {22'h0, idx, 2'b00};
    htrans <= stic_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy;
    htrans <= stic_pkg::HTRANS_IDLE;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    bus(1'b1, idx, wd, rd);
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, idx, 32'h0, rd);
    chk(nm, rd, exp);
    chk("hresp", hresp, 32'h0);
  endtask
  // wait for the selected strobe, then expect that pin level
  task automatic rx_check(input logic ft);
    int n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while ((ft ? fixed_strobe : adaptive_strobe) !== 1'b1 && n < 40);
    if ((ft ? fixed_strobe : adaptive_strobe) !== 1'b1)
    begin
      bad_count++;
      report_and_stop;
    end
    last_rx = rx_pin;
    #1;
    chk("rx_valid", rx_bit_valid, 32'h1);
    chk("rx_bit", rx_bit, last_rx);
  endtask
  // expected line bit for a slot: loopback first, then framing override
  function automatic logic exp_tx(logic [2:0] s, logic b, logic mf, logic [2:0] lb);
    if (s <= 3'h2 && lb[s])
      return last_rx;
    if (!mf && (s == 3'h3 || s == 3'h4))
      return 1'b0;
    if (!mf && s == 3'h5)
      return 1'b1;
    return b;
  endfunction
  task automatic tx(input logic [2:0] s, input logic mf, input logic [2:0] lb);
    logic b;
    b = 1'($urandom);
    @(posedge clock);
    bit_strobe <= 1'b1;
    tx_slot <= s;
    tx_bit_in <= b;
    @(posedge clock);
    bit_strobe <= 1'b0;
    #1;
    chk("tx_bit", tx_bit, exp_tx(s, b, mf, lb));
  endtask
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial
  begin
    void'($urandom(32'h4780));
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    rdc("timing", TIM, 32'h02);
    rdc("loop", LOOP, 32'h0);
    rdc("mf_a", stic_pkg::IDX_MF_A, 32'h0F);
    rdc("mf_b", stic_pkg::IDX_MF_B, 32'h0);
    rdc("unmapped", 8'h12, 32'h0);
    $display("test reset_values done");
    // reserved bits must drop out of every readback
    for (int i = 0; i < 12; i++)
    begin
      d = $urandom;
      wr(LOOP, d);
      rdc("loop", LOOP, d & 32'h1E);
      chk("deact", forced_deactivation, d[1]);
      chk("lb", {loopback_d_channel, loopback_b2_channel, loopback_b1_channel}, d[4:2]);
      d = $urandom & 32'hFFFFFFFE; // bit 0 clear: no soft reset here
      wr(TIM, d);
      rdc("timing", TIM, d & 32'h3E);
      chk("enable", interface_enable, d[1]);
      chk("force", force_full_activation, d[4] & d[1]);
      chk("local", local_only_activation, d[5] & d[1]);
      chk("fixed", fixed_sample_timing, d[3]);
      chk("mf_en", multiframe_enable, d[2]);
      if (!d[2])
      begin
        chk("mfa_lo", multiframe_reg_a[3:0], 32'hF);
        chk("mfb_lo", multiframe_reg_b[3:0], 32'h0);
      end
    end
    $display("test random_regs done");
    // lock under force, released by clearing the force bit
    wr(TIM, 32'h12);
    @(posedge clock);
    u_activation_event <= 1'b1;
    @(posedge clock);
    u_activation_event <= 1'b0;
    repeat (2) @(posedge clock);
    chk("lock", u_activation_ignore, 32'h1);
    wr(TIM, 32'h02);
    // force bit lands at the data phase edge, lock drops one edge later
    repeat (2) @(posedge clock);
    chk("lock", u_activation_ignore, 32'h0);
    $display("test force_lock done");
    for (int s = 0; s < 8; s++)
    begin
      @(posedge clock);
      activation_state <= 3'(s);
      @(posedge clock);
      #1;
      chk("full_act", full_activation, 32'(s == 3));
      rdc("status", stic_pkg::IDX_STATUS, 32'(s));
    end
    $display("test state_codes done");
    // soft reset clears loop ctrl, keeps enable, reads back zero
    wr(LOOP, 32'h1E);
    d = 32'(pulses);
    wr(TIM, 32'h03);
    repeat (3) @(posedge clock);
    chk("pulses", 32'(pulses), d + 32'h1);
    rdc("timing", TIM, 32'h02);
    rdc("loop", LOOP, 32'h0);
    // multiframe registers free while enabled, low nibbles pinned when off
    wr(TIM, 32'h06);
    wr(stic_pkg::IDX_MF_A, 32'hA5);
    wr(stic_pkg::IDX_MF_B, 32'h5A);
    rdc("mf_a", stic_pkg::IDX_MF_A, 32'hA5);
    rdc("mf_b", stic_pkg::IDX_MF_B, 32'h5A);
    wr(TIM, 32'h02);
    rdc("mf_a", stic_pkg::IDX_MF_A, 32'hAF);
    rdc("mf_b", stic_pkg::IDX_MF_B, 32'h50);
    $display("test soft_reset done");
    // both sample points, framing with and without multiframing, loopback
    for (int ft = 0; ft < 2; ft++)
    begin
      wr(TIM, 32'h02 | 32'(ft << 3));
      repeat (3) rx_check(1'(ft));
      for (int s = 0; s < 7; s++)
        tx(3'(s), 1'b0, 3'h0);
      wr(TIM, 32'h06 | 32'(ft << 3));
      for (int s = 0; s < 7; s++)
        tx(3'(s), 1'b1, 3'h0);
      wr(LOOP, 32'h1C);
      rx_check(1'(ft));
      for (int s = 0; s < 3; s++)
        tx(3'(s), 1'b1, 3'h7);
      wr(LOOP, 32'h0);
    end
    $display("test rx_tx done");
    report_and_stop;
  end
endmodule
`default_nettype wire
